// ==== rtl/ddr_consts.svh ====
// Shared constants for the DDR3 mode control link ends
`ifndef DDR_CONSTS_SVH
`define DDR_CONSTS_SVH
// ------------------------------------------------------------------
// Clock and device timing
// ------------------------------------------------------------------
`define SYS_MHZ 40
`define T_CKSRE_NS 10
`define CKSRE_CYC ((`T_CKSRE_NS*`SYS_MHZ+999)/1000)
`define TDLLK_NCK 10'd512
// ------------------------------------------------------------------
// Positions in the sampled pin bundle
// ------------------------------------------------------------------
`define SYNC_W 28
`define P_CK 27
`define P_CKE 26
`define P_ODT 25
`define P_CMD 21
`define P_BA 18
`define P_ADDR 2
`define P_DQS 0
// ------------------------------------------------------------------
// Commands {cs_n, ras_n, cas_n, we_n} and mode register selects
// ------------------------------------------------------------------
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_NOP 4'h7
`define MR0 3'h0
`define MR1 3'h1
`define MR2 3'h2
// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define A_DLL_OFF 0
`define A_RTT0 2
`define A_RTT1 6
`define A_RTT2 9
`define A_WL 7
`define A_QOFF 12
`define A_DLL_RST 8
`define A_CL 4
`define A_CL_LO 2
`define CL6_CODE 3'h2
`define A_CWL 3
`define CWL6_CODE 3'h1
// Mode register values written by the controller
`define MR1_DLL_OFF_V 16'h0001
`define MR1_ON_V 16'h0000
`define MR1_WL_V 16'h0084
`define MR0_RST_V 16'h0120
`define MR0_CL6_V 16'h0020
`define MR2_CWL6_V 16'h0008
// ------------------------------------------------------------------
// Controller waits in link clock cycles, divider half periods
// ------------------------------------------------------------------
`define TMRD_NCK 10'd4
`define TMOD_NCK 10'd12
`define TXS_NCK 10'd5
`define TXP_NCK 10'd3
`define TCKSRE_NCK 10'd5
`define TCKSRX_NCK 10'd5
`define WL_GAP 3'd4
`define CK_HALF_FAST 4'd4
`define CK_HALF_SLOW 4'd8
`endif

// ==== rtl/ddr_ctrl_end.sv ====
// Controller end: runs DLL switch, clock change and leveling steps
`timescale 1ns/1ps
`default_nettype none
`include "ddr_consts.svh"
module ddr_ctrl_end (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  ddr_link_if.ctrl          link,
  input  wire logic         start_i,
  input  wire ddr_pkg::op_t op_i,
  output logic              busy_o,
  output logic              done_o,
  output logic [3:0]        lvl_delay_o
);
  import ddr_pkg::*;

  // ----------------------------------------------------------------
  // Step tables for each operation
  // ----------------------------------------------------------------
  function automatic seq_t seq_step(input op_t op, input logic [2:0] i);
    seq_t s;
    s = '{AC_END, 10'h000, 16'h0000};
    case ({op, i})
      {OP_DLL_OFF, 3'h0}: s = '{AC_MR1, `TMOD_NCK, `MR1_DLL_OFF_V};
      {OP_DLL_OFF, 3'h1}: s = '{AC_SRE, `TCKSRE_NCK, 16'h0000};
      {OP_DLL_OFF, 3'h2}: s = '{AC_FREQ, `TCKSRX_NCK, 16'h0001};
      {OP_DLL_OFF, 3'h3}: s = '{AC_EXIT, `TXS_NCK, 16'h0000};
      {OP_DLL_OFF, 3'h4}: s = '{AC_MR0, `TMRD_NCK, `MR0_CL6_V};
      {OP_DLL_OFF, 3'h5}: s = '{AC_MR2, `TMOD_NCK, `MR2_CWL6_V};
      {OP_DLL_ON, 3'h0}:  s = '{AC_SRE, `TCKSRE_NCK, 16'h0000};
      {OP_DLL_ON, 3'h1}:  s = '{AC_FREQ, `TCKSRX_NCK, 16'h0000};
      {OP_DLL_ON, 3'h2}:  s = '{AC_EXIT, `TXS_NCK, 16'h0000};
      {OP_DLL_ON, 3'h3}:  s = '{AC_MR1, `TMRD_NCK, `MR1_ON_V};
      {OP_DLL_ON, 3'h4}:  s = '{AC_MR0, `TMRD_NCK, `MR0_RST_V};
      {OP_DLL_ON, 3'h5}:  s = '{AC_MR2, `TMOD_NCK, `MR2_CWL6_V};
      {OP_DLL_ON, 3'h6}:  s = '{AC_WAIT, `TDLLK_NCK, 16'h0000};
      {OP_PD_FREQ, 3'h0}: s = '{AC_ODT, `TMOD_NCK, 16'h0000};
      {OP_PD_FREQ, 3'h1}: s = '{AC_PDE, `TCKSRE_NCK, 16'h0000};
      {OP_PD_FREQ, 3'h2}: s = '{AC_FREQ, `TCKSRX_NCK, 16'h0000};
      {OP_PD_FREQ, 3'h3}: s = '{AC_EXIT, `TXP_NCK, 16'h0000};
      {OP_PD_FREQ, 3'h4}: s = '{AC_MR0, `TMOD_NCK, `MR0_RST_V};
      {OP_PD_FREQ, 3'h5}: s = '{AC_WAIT, `TDLLK_NCK, 16'h0000};
      {OP_WLVL, 3'h0}:    s = '{AC_MR1, `TMOD_NCK, `MR1_WL_V};
      {OP_WLVL, 3'h1}:    s = '{AC_ODT, `TMOD_NCK, 16'h0001};
      {OP_WLVL, 3'h2}:    s = '{AC_LVL, 10'h000, 16'h0000};
      {OP_WLVL, 3'h3}:    s = '{AC_ODT, `TMOD_NCK, 16'h0000};
      {OP_WLVL, 3'h4}:    s = '{AC_MR1, `TMOD_NCK, `MR1_ON_V};
      default:            s = '{AC_END, 10'h000, 16'h0000};
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic       ck;
  logic       next_ck;
  logic       slow;
  logic [3:0] half;
  logic       ck_fall;
  logic [4:0] pos;

  assign half    = slow ? `CK_HALF_SLOW : `CK_HALF_FAST;
  assign ck_fall = ck & (div_cnt == half - 4'h1);
  assign pos     = ck ? {1'b0, div_cnt} : {1'b0, div_cnt} + {1'b0, half};

  // Divide the system clock down to the link clock
  always_comb begin
    next_div_cnt = div_cnt + 4'h1;
    next_ck      = ck;
    if (div_cnt >= half - 4'h1) begin
      next_div_cnt = 4'h0;
      next_ck      = ~ck;
    end
  end

  // Register the divider
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 4'h0;
      ck      <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ck      <= next_ck;
    end
  end

  // ----------------------------------------------------------------
  // Feedback synchroniser
  // ----------------------------------------------------------------
  logic [1:0] q1;
  logic [1:0] q2;

  // Two stages on the prime data lines
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q1 <= 2'h0;
      q2 <= 2'h0;
    end else begin
      q1 <= link.dq;
      q2 <= q1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ctl_state_t  cs;
  ctl_state_t  next_cs;
  op_t         op;
  op_t         next_op;
  logic [2:0]  idx;
  logic [2:0]  next_idx;
  logic [9:0]  wcnt;
  logic [9:0]  next_wcnt;
  logic        cke;
  logic        next_cke;
  logic        odt;
  logic        next_odt;
  logic [3:0]  cmd;
  logic [3:0]  next_cmd;
  logic [2:0]  ba;
  logic [2:0]  next_ba;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic        next_slow;
  logic        next_busy;
  logic        next_done;
  logic [3:0]  dly;
  logic [3:0]  next_dly;
  logic [3:0]  next_lvl;
  logic        fbp;
  logic        next_fbp;
  logic [2:0]  lck;
  logic [2:0]  next_lck;
  logic [3:0]  pcnt;
  logic [3:0]  next_pcnt;
  logic        dqs;
  logic        next_dqs;
  logic        dqs_oe_n;
  logic        next_dqs_oe_n;
  seq_t        cur;

  assign cur = seq_step(op, idx);

  // Next values of the sequencer; commands change on link clock fall
  always_comb begin
    next_cs = cs;
    next_op = op;
    next_idx = idx;
    next_wcnt = wcnt;
    next_cke = cke;
    next_odt = odt;
    next_cmd = cmd;
    next_ba = ba;
    next_addr = addr;
    next_slow = slow;
    next_busy = busy_o;
    next_done = 1'b0;
    next_dly = dly;
    next_lvl = lvl_delay_o;
    next_fbp = fbp;
    next_lck = lck;
    next_pcnt = pcnt;
    next_dqs = dqs;
    next_dqs_oe_n = dqs_oe_n;
    if (ck_fall) begin
      next_cmd  = `CMD_NOP;
      next_ba   = 3'h0;
      next_addr = 16'h0000;
    end
    case (cs)
      CS_IDLE: begin
        if (start_i) begin
          next_op   = op_i;
          next_idx  = 3'h0;
          next_cs   = CS_ISSUE;
          next_busy = 1'b1;
        end
      end
      CS_ISSUE: begin
        if (ck_fall) begin
          next_wcnt = cur.wt;
          next_cs   = CS_WAIT;
          case (cur.act)
            AC_MR0, AC_MR1, AC_MR2: begin
              next_cmd  = `CMD_MRS;
              next_addr = cur.val;
              next_ba   = (cur.act == AC_MR1) ? `MR1 :
                          (cur.act == AC_MR2) ? `MR2 : `MR0;
            end
            AC_SRE: begin
              next_cmd = `CMD_REF;
              next_cke = 1'b0;
            end
            AC_PDE: next_cke = 1'b0;
            AC_FREQ: next_slow = cur.val[0];
            AC_EXIT: next_cke = 1'b1;
            AC_ODT: next_odt = cur.val[0];
            AC_LVL: begin
              next_cs       = CS_LVL;
              next_lck      = 3'h0;
              next_fbp      = 1'b1;
              next_dly      = 4'h0;
              next_dqs_oe_n = 1'b0;
            end
            AC_END: begin
              next_cs   = CS_IDLE;
              next_busy = 1'b0;
              next_done = 1'b1;
            end
            default: next_cs = CS_WAIT;
          endcase
        end
      end
      CS_WAIT: begin
        if (ck_fall) begin
          next_wcnt = wcnt - 10'h001;
          if (wcnt <= 10'h001) begin
            next_idx = idx + 3'h1;
            next_cs  = CS_ISSUE;
          end
        end
      end
      CS_LVL: begin
        if (pcnt != 4'h0) begin
          next_pcnt = pcnt - 4'h1;
          next_dqs  = (pcnt != 4'h1);
        end else if (lck == 3'h1 && pos == {1'b0, dly}) begin
          next_pcnt = half;
          next_dqs  = 1'b1;
        end
        if (ck_fall) begin
          next_lck = lck + 3'h1;
        end
        if (ck_fall && lck == `WL_GAP) begin
          next_lck = 3'h0;
          if (!fbp && q2[0]) begin
            next_lvl      = dly;
            next_dqs_oe_n = 1'b1;
            next_idx      = idx + 3'h1;
            next_cs       = CS_ISSUE;
          end else begin
            next_fbp = q2[0];
            next_dly = ({1'b0, dly} == {half, 1'b0} - 5'h01) ?
                       4'h0 : dly + 4'h1;
          end
        end
      end
      default: next_cs = CS_IDLE;
    endcase
  end

  // Register the sequencer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs          <= CS_IDLE;
      op          <= OP_DLL_OFF;
      idx         <= 3'h0;
      wcnt        <= 10'h000;
      cke         <= 1'b1;
      odt         <= 1'b0;
      cmd         <= `CMD_NOP;
      ba          <= 3'h0;
      addr        <= 16'h0000;
      slow        <= 1'b0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      dly         <= 4'h0;
      lvl_delay_o <= 4'h0;
      fbp         <= 1'b1;
      lck         <= 3'h0;
      pcnt        <= 4'h0;
      dqs         <= 1'b0;
      dqs_oe_n    <= 1'b1;
    end else begin
      cs          <= next_cs;
      op          <= next_op;
      idx         <= next_idx;
      wcnt        <= next_wcnt;
      cke         <= next_cke;
      odt         <= next_odt;
      cmd         <= next_cmd;
      ba          <= next_ba;
      addr        <= next_addr;
      slow        <= next_slow;
      busy_o      <= next_busy;
      done_o      <= next_done;
      dly         <= next_dly;
      lvl_delay_o <= next_lvl;
      fbp         <= next_fbp;
      lck         <= next_lck;
      pcnt        <= next_pcnt;
      dqs         <= next_dqs;
      dqs_oe_n    <= next_dqs_oe_n;
    end
  end

  // Link pins from registers
  assign link.ck       = ck;
  assign link.cke      = cke;
  assign link.odt      = odt;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd;
  assign link.ba       = ba;
  assign link.addr     = addr;
  assign link.dqs_out  = {2{dqs}};
  assign link.dqs_oe_n = {2{dqs_oe_n}};
endmodule
`default_nettype wire

// ==== rtl/ddr_dev_end.sv ====
// Device end: DLL switching, clock change states, write leveling
// Operation
// - MR1 A0 high turns DLL off
// - DLL off switch follows fixed order
// - DLL on switch through self refresh
// - Hold CKE high, ODT low until lock
// - Wait tXS before enabling DLL
// - Wait tMRD, then remaining mode registers
// - Wait tMOD, tDLLK before commands
// - Change frequency only in self refresh, power-down
// - Clock ignored after tCKSRE in self refresh
// - Wait tCKSRE after CKE low
// - ODT and CKE low during change
// - Termination off before frequency change
// - Stable clock, exit, then DLL reset
// - ODT low, CKE high during relock
// - Leveling samples CK on DQS rise
// - Controller steps delay until 0 to 1
// - Separate feedback per byte lane
// - MR1 A7 leveling, A12 output off
// - Leveling ODT switches strobe termination only
// - Leveling with outputs restricts nominal termination
// - Only NOP or deselect while leveling
// - DLL off needs only CL6, CWL6
`timescale 1ns/1ps
`default_nettype none
`include "ddr_consts.svh"
module ddr_dev_end (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_n_i,
  ddr_link_if.device               link,
  output var  ddr_pkg::dev_state_t state_o,
  output logic                     dll_on_o,
  output logic                     dll_locked_o,
  output logic                     clk_ignored_o,
  output logic                     wl_active_o,
  output logic                     strobe_term_o,
  output logic                     data_term_o,
  output logic                     latency_ok_o
);
  import ddr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [`SYNC_W-1:0] pins;
  logic [`SYNC_W-1:0] s1;
  logic [`SYNC_W-1:0] s2;
  logic [`SYNC_W-1:0] s3;
  logic               ck_s;
  logic               ck_rise;
  logic               cke_s;
  logic               odt_s;
  logic [3:0]         cmd;
  logic [2:0]         ba;
  logic [15:0]        a;
  logic [1:0]         dqs_rise;
  logic               mrs;

  // Gather all link inputs into one bundle
  assign pins = {link.ck, link.cke, link.odt, link.cs_n, link.ras_n,
                 link.cas_n, link.we_n, link.ba, link.addr, link.dqs};

  // Two stages, plus a third for edge detection
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Decoded fields of the second stage
  assign ck_s     = s2[`P_CK];
  assign ck_rise  = s2[`P_CK] & ~s3[`P_CK];
  assign cke_s    = s2[`P_CKE];
  assign odt_s    = s2[`P_ODT];
  assign cmd      = s2[`P_CMD +: 4];
  assign ba       = s2[`P_BA +: 3];
  assign a        = s2[`P_ADDR +: 16];
  assign dqs_rise = s2[`P_DQS +: 2] & ~s3[`P_DQS +: 2];
  assign mrs      = ck_rise & cke_s & (cmd == `CMD_MRS)
                    & (state_o == ST_IDLE);

  // ----------------------------------------------------------------
  // Mode, power state and leveling state
  // ----------------------------------------------------------------
  dev_state_t  next_st;
  logic        next_dll_on;
  logic        next_locked;
  logic        next_ign;
  logic        next_wl;
  logic        qoff;
  logic        next_qoff;
  logic        rtt_nom;
  logic        next_rtt_nom;
  logic        cl6;
  logic        next_cl6;
  logic        cwl6;
  logic        next_cwl6;
  logic [9:0]  lock_cnt;
  logic [9:0]  next_lock_cnt;
  logic [7:0]  sr_cnt;
  logic [7:0]  next_sr_cnt;
  logic [1:0]  fb;
  logic [1:0]  next_fb;
  logic        drv_n;
  logic        next_drv_n;
  logic        next_strobe;
  logic        next_data;
  logic        next_latok;

  // Next values of the device state
  always_comb begin
    next_st       = state_o;
    next_dll_on   = dll_on_o;
    next_locked   = dll_locked_o;
    next_ign      = clk_ignored_o;
    next_wl       = wl_active_o;
    next_qoff     = qoff;
    next_rtt_nom  = rtt_nom;
    next_cl6      = cl6;
    next_cwl6     = cwl6;
    next_lock_cnt = lock_cnt;
    next_sr_cnt   = sr_cnt;
    next_fb       = fb;
    // Mode register writes
    if (mrs && ba == `MR1) begin
      next_dll_on  = ~a[`A_DLL_OFF];
      next_wl      = a[`A_WL];
      next_qoff    = a[`A_QOFF];
      next_rtt_nom = a[`A_RTT0] | a[`A_RTT1] | a[`A_RTT2];
      if (a[`A_DLL_OFF]) begin
        next_locked   = 1'b0;
        next_lock_cnt = 10'h000;
      end
    end
    if (mrs && ba == `MR0) begin
      next_cl6 = (a[`A_CL +: 3] == `CL6_CODE) & ~a[`A_CL_LO];
      if (a[`A_DLL_RST] && dll_on_o) begin
        next_lock_cnt = `TDLLK_NCK;
        next_locked   = 1'b0;
      end
    end
    if (mrs && ba == `MR2) begin
      next_cwl6 = (a[`A_CWL +: 3] == `CWL6_CODE);
    end
    // DLL lock counts link clock edges
    if (ck_rise && lock_cnt != 10'h000 && !mrs) begin
      next_lock_cnt = lock_cnt - 10'h001;
      if (lock_cnt == 10'h001) begin
        next_locked = 1'b1;
      end
    end
    // Self refresh and precharge power-down
    case (state_o)
      ST_IDLE: begin
        if (ck_rise && !cke_s) begin
          next_st     = (cmd == `CMD_REF) ? ST_SREF : ST_PDN;
          next_sr_cnt = 8'h00;
          next_ign    = 1'b0;
        end
      end
      ST_SREF, ST_PDN: begin
        if (!clk_ignored_o) begin
          next_sr_cnt = sr_cnt + 8'h01;
          if (sr_cnt >= 8'(`CKSRE_CYC - 1)) begin
            next_ign = 1'b1;
          end
        end
        if (ck_rise && cke_s) begin
          next_st  = ST_IDLE;
          next_ign = 1'b0;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    // Leveling feedback, one bit per byte lane
    for (int i = 0; i < 2; i++) begin
      if (!next_wl) begin
        next_fb[i] = 1'b0;
      end else if (dqs_rise[i]) begin
        next_fb[i] = ck_s;
      end
    end
    // Feedback drivers follow the new mode so they drop with the data
    next_drv_n  = ~(next_wl & ~next_qoff);
    next_strobe = wl_active_o & odt_s & (state_o == ST_IDLE);
    next_data   = ~wl_active_o & odt_s & rtt_nom
                  & (state_o != ST_SREF);
    next_latok  = dll_on_o | (cl6 & cwl6);
  end

  // Register the device state
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_o       <= ST_IDLE;
      dll_on_o      <= 1'b1;
      dll_locked_o  <= 1'b0;
      clk_ignored_o <= 1'b0;
      wl_active_o   <= 1'b0;
      qoff          <= 1'b0;
      rtt_nom       <= 1'b0;
      cl6           <= 1'b0;
      cwl6          <= 1'b0;
      lock_cnt      <= 10'h000;
      sr_cnt        <= 8'h00;
      fb            <= 2'h0;
      drv_n         <= 1'b1;
      strobe_term_o <= 1'b0;
      data_term_o   <= 1'b0;
      latency_ok_o  <= 1'b1;
    end else begin
      state_o       <= next_st;
      dll_on_o      <= next_dll_on;
      dll_locked_o  <= next_locked;
      clk_ignored_o <= next_ign;
      wl_active_o   <= next_wl;
      qoff          <= next_qoff;
      rtt_nom       <= next_rtt_nom;
      cl6           <= next_cl6;
      cwl6          <= next_cwl6;
      lock_cnt      <= next_lock_cnt;
      sr_cnt        <= next_sr_cnt;
      fb            <= next_fb;
      drv_n         <= next_drv_n;
      strobe_term_o <= next_strobe;
      data_term_o   <= next_data;
      latency_ok_o  <= next_latok;
    end
  end

  // Prime data lines toward the controller
  assign link.dq_out  = fb;
  assign link.dq_oe_n = {2{drv_n}};
endmodule
`default_nettype wire

// ==== rtl/ddr_link_if.sv ====
// Link between the DDR3 device end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
  logic        ck;
  logic        cke;
  logic        odt;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [1:0]  dqs_out;
  logic [1:0]  dqs_oe_n;
  logic [1:0]  dq_out;
  logic [1:0]  dq_oe_n;
  logic [1:0]  dqs;
  logic [1:0]  dq;
  // Wire levels; an undriven line reads low
  assign dqs = dqs_out & ~dqs_oe_n;
  assign dq  = dq_out & ~dq_oe_n;
  modport device (input ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba,
                  addr, dqs, output dq_out, dq_oe_n);
  modport ctrl (output ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba,
                addr, dqs_out, dqs_oe_n, input dq);
endinterface
`default_nettype wire

// ==== rtl/ddr_pkg.sv ====
// Types shared by the DDR3 mode control link ends
package ddr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PDN  = 2'b01,
    ST_SREF = 2'b10
  } dev_state_t;
  typedef enum logic [1:0] {
    OP_DLL_OFF = 2'b00,
    OP_DLL_ON  = 2'b01,
    OP_PD_FREQ = 2'b10,
    OP_WLVL    = 2'b11
  } op_t;
  typedef enum logic [3:0] {
    AC_END  = 4'b0000,
    AC_MR0  = 4'b0001,
    AC_MR1  = 4'b0010,
    AC_MR2  = 4'b0011,
    AC_SRE  = 4'b0100,
    AC_PDE  = 4'b0101,
    AC_FREQ = 4'b0110,
    AC_EXIT = 4'b0111,
    AC_ODT  = 4'b1000,
    AC_LVL  = 4'b1001,
    AC_WAIT = 4'b1010
  } act_t;
  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_ISSUE = 2'b01,
    CS_WAIT  = 2'b10,
    CS_LVL   = 2'b11
  } ctl_state_t;
  typedef struct packed {
    act_t        act;
    logic [9:0]  wt;
    logic [15:0] val;
  } seq_t;
endpackage

// ==== verification/ddr_dll_clock_change_write_leveling_tb_top.sv ====
// Testbench for the DDR3 mode control link ends
`timescale 1ns/1ps
`default_nettype none
`include "ddr_consts.svh"
module ddr_dll_clock_change_write_leveling_tb_top;
  import ddr_pkg::*;
  logic sys_clk_i, reset_n_i, start_i, busy_o, done_o;
  logic dll_on_o, dll_locked_o, clk_ignored_o, wl_active_o;
  logic strobe_term_o, data_term_o, latency_ok_o, exp_on, exp_lock, exp_fast;
  logic [3:0] lvl_delay_o;
  op_t        op_i;
  dev_state_t state_o;
  int         num_errors, num_checks;
  ddr_link_if i_ddr_link_if ();
  ddr_dev_end i_ddr_dev_end (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .link(i_ddr_link_if), .state_o(state_o), .dll_on_o(dll_on_o),
    .dll_locked_o(dll_locked_o), .clk_ignored_o(clk_ignored_o),
    .wl_active_o(wl_active_o), .strobe_term_o(strobe_term_o),
    .data_term_o(data_term_o), .latency_ok_o(latency_ok_o));
  ddr_ctrl_end i_ddr_ctrl_end (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .link(i_ddr_link_if), .start_i(start_i), .op_i(op_i), .busy_o(busy_o),
    .done_o(done_o), .lvl_delay_o(lvl_delay_o));
  ddr_link_asserts i_ddr_link_asserts (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .ck(i_ddr_link_if.ck), .cke(i_ddr_link_if.cke),
    .odt(i_ddr_link_if.odt), .cs_n(i_ddr_link_if.cs_n),
    .ras_n(i_ddr_link_if.ras_n), .cas_n(i_ddr_link_if.cas_n),
    .we_n(i_ddr_link_if.we_n), .ba(i_ddr_link_if.ba),
    .addr(i_ddr_link_if.addr), .dqs(i_ddr_link_if.dqs),
    .dqs_oe_n(i_ddr_link_if.dqs_oe_n), .dq_out(i_ddr_link_if.dq_out),
    .dq_oe_n(i_ddr_link_if.dq_oe_n));
  // Clock
  always #12.5 sys_clk_i = ~sys_clk_i;
  // First strobe delay whose clock sample goes 0 to 1; the strobe
  // leaves one cycle after its delay count, delays wrap at one period
  function automatic logic [3:0] lock_at(input int half);
    logic prev, cur;
    prev = 1'b1;
    for (int d = 0; d < 2 * half; d++) begin
      cur = ((d + 1) % (2 * half)) < half;
      if (!prev && cur) return d[3:0];
      prev = cur;
    end
    return 4'h0;
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait on a level at falling edges: 0 lock, 1 done, 2 strobe term
  task automatic wait_for(input logic want, input int sel);
    int n;
    n = 0;
    while ((((sel == 1) ? done_o : (sel == 2) ? strobe_term_o : dll_locked_o)
            !== want) && n < 30000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 30000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic run_op(input op_t op);
    @(posedge sys_clk_i);
    op_i <= op;
    start_i <= 1'b1;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    if (op == OP_WLVL) begin
      wait_for(1'b1, 2);
      chk(data_term_o, 4'h0);
      chk(wl_active_o, 4'h1);
    end
    wait_for(1'b1, 1'b1);
    case (op)
      OP_DLL_OFF: begin
        {exp_on, exp_lock, exp_fast} = 3'b000;
        chk(dll_on_o, 4'h0);
      end
      OP_DLL_ON: begin
        {exp_on, exp_lock, exp_fast} = 3'b111;
        chk(dll_on_o, 4'h1);
      end
      OP_PD_FREQ: begin
        exp_lock = exp_on;
        exp_fast = 1'b1;
      end
      default: begin
        exp_on = 1'b1;
        chk(lvl_delay_o, lock_at(int'(`CK_HALF_FAST)));
        chk(wl_active_o, 4'h0);
      end
    endcase
    wait_for(exp_lock, 1'b0);
    chk(dll_locked_o, exp_lock);
    chk(state_o, ST_IDLE);
    chk(clk_ignored_o, 4'h0);
    chk(latency_ok_o, 4'h1);
    chk(strobe_term_o, 4'h0);
    chk(busy_o, 4'h0);
    $display("test op=%0d done", op);
  endtask
  initial begin
    op_t op;
    sys_clk_i = 1'b0;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    op_i = OP_DLL_OFF;
    {exp_on, exp_lock, exp_fast} = 3'b101;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(84556));
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    // Corner order: leveling, slow clock, power-down change with DLL off
    run_op(OP_WLVL);
    run_op(OP_DLL_OFF);
    run_op(OP_PD_FREQ);
    run_op(OP_DLL_ON);
    run_op(OP_WLVL);
    for (int i = 0; i < 6; i++) begin
      op = op_t'($urandom_range(0, 3));
      if (op == OP_WLVL && !exp_fast) op = OP_DLL_ON;
      run_op(op);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== verification/ddr_link_asserts.sv ====
// Interface checker for the DDR3 mode control link
`timescale 1ns/1ps
`default_nettype none
module ddr_link_asserts (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        ck,
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [15:0] addr,
  input wire logic [1:0]  dqs,
  input wire logic [1:0]  dqs_oe_n,
  input wire logic [1:0]  dq_out,
  input wire logic [1:0]  dq_oe_n
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic       mrs;
  logic       ck_d, next_ck_d;
  logic [1:0] seen, next_seen;
  logic [3:0] age, next_age, hcnt, next_hcnt, hlast, next_hlast;
  assign mrs = ({cs_n, ras_n, cas_n, we_n} == 4'h0);
  // Strobe age and link clock half period lengths
  always_comb begin
    next_age = dqs[0] ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
    next_ck_d = ck;
    next_hcnt = (ck != ck_d) ? 4'h1 : ((hcnt == 4'hf) ? hcnt : hcnt + 4'h1);
    next_hlast = (ck != ck_d) ? hcnt : hlast;
    next_seen = ((ck != ck_d) && (seen != 2'h3)) ? seen + 2'h1 : seen;
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {age, ck_d, hcnt, hlast, seen} <= '0;
    end else begin
      age <= next_age;
      ck_d <= next_ck_d;
      hcnt <= next_hcnt;
      hlast <= next_hlast;
      seen <= next_seen;
    end
  end
  property p_mrs_cke; mrs |-> cke; endproperty
  a_mrs_cke: assert property (p_mrs_cke) else $error("mode write, cke low");
  property p_dll_off_odt; mrs && ba == 3'h1 && addr[0] |-> !odt; endproperty
  a_dll_off_odt: assert property (p_dll_off_odt) else $error("odt high");
  property p_mrs_gap; $fell(mrs) |-> !mrs [*8]; endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("mode writes close");
  property p_odt_cke; !cke |-> !odt; endproperty
  a_odt_cke: assert property (p_odt_cke) else $error("odt high, cke low");
  property p_freq_cke; ck != ck_d && seen == 2'h3 && hcnt != hlast |-> !cke;
  endproperty
  a_freq_cke: assert property (p_freq_cke) else $error("rate change");
  property p_lvl_nop;
    dq_oe_n == 2'b00 |-> cs_n || mrs || (ras_n && cas_n && we_n);
  endproperty
  a_lvl_nop: assert property (p_lvl_nop) else $error("command in leveling");
  property p_dqs_lvl; !dqs_oe_n[0] |-> !dq_oe_n[0]; endproperty
  a_dqs_lvl: assert property (p_dqs_lvl) else $error("strobe outside mode");
  property p_fb_dqs; $changed(dq_out) && !dq_oe_n[0] && !$past(dq_oe_n[0])
    |-> age < 4'h7; endproperty
  a_fb_dqs: assert property (p_fb_dqs) else $error("feedback no strobe");
endmodule
`default_nettype wire
